/* rtl/tmcd_audio_sel.sv */
`timescale 1ns/100ps
`include "tmcd_regs.svh"
module tmcd_audio_sel (
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic load_in,
	input wire logic [2:0] code_in,
	output logic [2:0] route_out
);
	wire code_ok;
	assign code_ok = (code_in == `TMCD_AUD_NORMAL) ||
		(code_in == `TMCD_AUD_DECODER) ||
		(code_in == `TMCD_AUD_ENCODER) ||
		(code_in == `TMCD_AUD_ACOUSTIC);
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			route_out <= `TMCD_AUD_RESET;
		else if (load_in && code_ok)
			route_out <= code_in;
	end
endmodule

/* rtl/tmcd_decoder.sv */
`timescale 1ns/100ps
`include "tmcd_regs.svh"
module tmcd_decoder #(
	parameter logic [10:0] PDU_LEN_DECL = `TMCD_PDU_LEN_MAX,
	parameter bit UNLIMITED_OK = 1'b1,
	parameter bit BOTH_SOURCES = 1'b1
) (
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic rx_valid_in,
	input wire logic [7:0] rx_data_in,
	input wire logic rx_last_in,
	input wire logic tx_ready_in,
	input wire logic mode_a_in,
	output logic tx_valid_out,
	output logic [7:0] tx_data_out,
	output logic tx_last_out,
	output logic link_active_out,
	output logic mslot_open_out,
	output logic [2:0] audio_route_out,
	output logic pkt_test_out,
	output logic [11:0] pdu_count_field_out,
	output logic pdu_unlimited_out,
	output logic [10:0] pdu_len_out,
	output logic pdu_payload_only_out,
	output logic loopback_out,
	output logic [2:0] dl_ts_offset_out,
	output logic ignored_out
);
	tmcd_pkg::tmcd_state_t state;
	tmcd_pkg::tmcd_state_t next_state;
	logic [3:0] disc;
	logic [7:0] msg_type;
	logic [1:0] ie_idx;
	logic [7:0] ie0;
	logic [7:0] ie1;
	logic [7:0] ie2;
	logic [2:0] route;
	wire rx_hdr;
	wire rx_type;
	wire rx_ie;
	wire skip_bad;
	wire need_ie;
	wire [1:0] ie_need;
	wire msg_end;
	wire ie_done;
	wire is_open;
	wire is_act;
	wire is_deact;
	wire is_audio;
	wire is_pkt;
	wire pkt_ok;
	wire send_reply;
	wire [7:0] reply_type;
	wire [3:0] skip_field;
	wire [11:0] cnt_field;
	wire cnt_zero;
	wire lsel_rsv;
	wire pkt_take;
	wire aud_load;
	wire [2:0] aud_code;
	wire mode_a_agree;
	logic mode_a_s1;
	logic mode_a_s2;
	logic mode_a_s3;
	logic mode_a;

	assign rx_hdr = rx_valid_in && (state == tmcd_pkg::TMCD_S_HDR);
	assign rx_type = rx_valid_in && (state == tmcd_pkg::TMCD_S_TYPE);
	assign rx_ie = rx_valid_in && (state == tmcd_pkg::TMCD_S_IE);
	assign skip_field = rx_data_in[`TMCD_SKIP_MSB:`TMCD_SKIP_LSB];
	assign skip_bad = skip_field != `TMCD_SKIP_OK;
	assign ie_need = (rx_data_in == `TMCD_MT_PKT_TEST_REQ) ? `TMCD_IE_PKT :
		(rx_data_in == `TMCD_MT_AUDIO_SEL) ? `TMCD_IE_AUD :
		`TMCD_IE_NONE;
	assign need_ie = ie_need != `TMCD_IE_NONE;
	assign msg_end = (state == tmcd_pkg::TMCD_S_DONE);
	assign ie_done = rx_ie && (ie_idx == 2'h0);
	assign is_open = msg_type == `TMCD_MT_OPEN_MSLOT_REQ;
	assign is_act = msg_type == `TMCD_MT_LINK_ACT_REQ;
	assign is_deact = msg_type == `TMCD_MT_LINK_DEACT_REQ;
	assign is_audio = msg_type == `TMCD_MT_AUDIO_SEL;
	assign is_pkt = msg_type == `TMCD_MT_PKT_TEST_REQ;
	assign lsel_rsv = mode_a && !ie0[`TMCD_LSEL_BIT];
	assign pkt_ok = ie0[`TMCD_LSEL_BIT] && mode_a;
	assign pkt_take = msg_end && is_pkt && !lsel_rsv;
	assign cnt_field = {ie0[`TMCD_CNT_HI_MSB:0], ie1};
	assign cnt_zero = cnt_field == `TMCD_CNT_UNLIMITED;
	assign aud_load = msg_end && is_audio;
	assign aud_code = ie2[`TMCD_AUD_MSB:0];
	assign mode_a_agree = mode_a_s2 == mode_a_s3;
	assign send_reply = msg_end && (is_open || is_act);
	assign reply_type = is_open ? `TMCD_MT_OPEN_MSLOT_REPLY :
		`TMCD_MT_LINK_ACT_REPLY;

	always_comb
	begin
		next_state = state;
		case (state)
			tmcd_pkg::TMCD_S_HDR:
			begin
				if (rx_valid_in && rx_last_in)
					next_state = tmcd_pkg::TMCD_S_HDR;
				else if (rx_valid_in && skip_bad)
					next_state = tmcd_pkg::TMCD_S_DROP;
				else if (rx_valid_in)
					next_state = tmcd_pkg::TMCD_S_TYPE;
			end
			tmcd_pkg::TMCD_S_TYPE:
			begin
				if (rx_valid_in && rx_last_in && need_ie)
					next_state = tmcd_pkg::TMCD_S_HDR;
				else if (rx_valid_in && rx_last_in)
					next_state = tmcd_pkg::TMCD_S_DONE;
				else if (rx_valid_in && need_ie)
					next_state = tmcd_pkg::TMCD_S_IE;
				else if (rx_valid_in)
					next_state = tmcd_pkg::TMCD_S_DROP;
			end
			tmcd_pkg::TMCD_S_IE:
			begin
				if (ie_done && rx_last_in)
					next_state = tmcd_pkg::TMCD_S_DONE;
				else if (ie_done)
					next_state = tmcd_pkg::TMCD_S_DROP;
				else if (rx_valid_in && rx_last_in)
					next_state = tmcd_pkg::TMCD_S_HDR;
			end
			tmcd_pkg::TMCD_S_DROP:
			begin
				if (rx_valid_in && rx_last_in)
					next_state = tmcd_pkg::TMCD_S_HDR;
			end
			tmcd_pkg::TMCD_S_DONE:
			begin
				next_state = tmcd_pkg::TMCD_S_HDR;
			end
			default:
			begin
				next_state = tmcd_pkg::TMCD_S_HDR;
			end
		endcase
	end

	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			state <= tmcd_pkg::TMCD_S_HDR;
		else
			state <= next_state;
	end

	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			disc <= 4'h0;
		else if (rx_hdr)
			disc <= rx_data_in[`TMCD_DISC_MSB:0];
	end

	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			msg_type <= 8'h00;
		else if (rx_type)
			msg_type <= rx_data_in;
	end

	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			ie_idx <= 2'h0;
		else if (rx_type)
			ie_idx <= ie_need - 2'h1;
		else if (rx_ie && ie_idx != 2'h0)
			ie_idx <= ie_idx - 2'h1;
	end

	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			ie0 <= 8'h00;
			ie1 <= 8'h00;
			ie2 <= 8'h00;
		end
		else if (rx_ie)
		begin
			ie0 <= ie1;
			ie1 <= ie2;
			ie2 <= rx_data_in;
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			ignored_out <= 1'b0;
		else
			ignored_out <= rx_hdr && skip_bad && !rx_last_in;
	end

	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			link_active_out <= 1'b0;
		else if (msg_end && is_act)
			link_active_out <= 1'b1;
		else if (msg_end && is_deact)
			link_active_out <= 1'b0;
	end

	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			mslot_open_out <= 1'b0;
		else if (msg_end && is_open)
			mslot_open_out <= 1'b1;
	end

	// Mode level filtered through three stages
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			mode_a_s1 <= 1'b0;
			mode_a_s2 <= 1'b0;
			mode_a_s3 <= 1'b0;
			mode_a <= 1'b0;
		end
		else
		begin
			mode_a_s1 <= mode_a_in;
			mode_a_s2 <= mode_a_s1;
			mode_a_s3 <= mode_a_s2;
			if (mode_a_agree)
				mode_a <= mode_a_s3;
		end
	end

	tmcd_audio_sel tmcd_audio_sel_inst (
		.clk_in(clk_in),
		.nrst_in(nrst_in),
		.load_in(aud_load),
		.code_in(aud_code),
		.route_out(route)
	);

	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			audio_route_out <= `TMCD_AUD_RESET;
		else
			audio_route_out <= route;
	end

	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			pkt_test_out <= 1'b0;
			pdu_payload_only_out <= 1'b0;
			loopback_out <= 1'b0;
			dl_ts_offset_out <= `TMCD_TS_RESET;
		end
		else if (pkt_take)
		begin
			pkt_test_out <= 1'b1;
			pdu_payload_only_out <= 1'b1;
			dl_ts_offset_out <= ie2[`TMCD_TS_MSB:`TMCD_TS_LSB];
			loopback_out <= BOTH_SOURCES && ie2[`TMCD_SRC_BIT];
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			pdu_count_field_out <= `TMCD_CNT_RESET;
			pdu_unlimited_out <= 1'b0;
			pdu_len_out <= `TMCD_PDU_LEN_MIN;
		end
		else if (pkt_take && pkt_ok)
		begin
			pdu_count_field_out <= cnt_field;
			pdu_unlimited_out <= UNLIMITED_OK && cnt_zero;
			pdu_len_out <= PDU_LEN_DECL;
		end
	end

	tmcd_reply_tx tmcd_reply_tx_inst (
		.clk_in(clk_in),
		.nrst_in(nrst_in),
		.send_in(send_reply),
		.type_in(reply_type),
		.disc_in(disc),
		.ready_in(tx_ready_in),
		.valid_out(tx_valid_out),
		.data_out(tx_data_out),
		.last_out(tx_last_out)
	);
endmodule

/* rtl/tmcd_pkg.sv */
package tmcd_pkg;
	typedef enum logic [4:0] {
		TMCD_S_HDR = 5'h01,
		TMCD_S_TYPE = 5'h02,
		TMCD_S_IE = 5'h04,
		TMCD_S_DROP = 5'h08,
		TMCD_S_DONE = 5'h10
	} tmcd_state_t;
endpackage

/* rtl/tmcd_regs.svh */
`ifndef TMCD_REGS_SVH
`define TMCD_REGS_SVH
`define TMCD_MT_OPEN_MSLOT_REQ 8'h22
`define TMCD_MT_OPEN_MSLOT_REPLY 8'h23
`define TMCD_MT_LINK_ACT_REQ 8'h0C
`define TMCD_MT_LINK_ACT_REPLY 8'h0D
`define TMCD_MT_LINK_DEACT_REQ 8'h10
`define TMCD_MT_AUDIO_SEL 8'h14
`define TMCD_MT_PKT_TEST_REQ 8'h24
`define TMCD_SKIP_OK 4'h0
`define TMCD_AUD_NORMAL 3'h0
`define TMCD_AUD_DECODER 3'h1
`define TMCD_AUD_ENCODER 3'h2
`define TMCD_AUD_ACOUSTIC 3'h4
`define TMCD_LSEL_BIT 7
`define TMCD_CNT_HI_MSB 3
`define TMCD_SRC_BIT 0
`define TMCD_TS_MSB 3
`define TMCD_TS_LSB 1
`define TMCD_PDU_LEN_MIN 11'h08C
`define TMCD_PDU_LEN_MAX 11'h618
`define TMCD_AUD_RESET 3'h0
`define TMCD_TS_RESET 3'h0
`define TMCD_CNT_RESET 12'h000
`define TMCD_CNT_UNLIMITED 12'h000
`define TMCD_SKIP_MSB 7
`define TMCD_SKIP_LSB 4
`define TMCD_DISC_MSB 3
`define TMCD_AUD_MSB 2
`define TMCD_IE_NONE 2'h0
`define TMCD_IE_AUD 2'h1
`define TMCD_IE_PKT 2'h3
`endif

/* rtl/tmcd_reply_tx.sv */
`timescale 1ns/100ps
`include "tmcd_regs.svh"
module tmcd_reply_tx (
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic send_in,
	input wire logic [7:0] type_in,
	input wire logic [3:0] disc_in,
	input wire logic ready_in,
	output logic valid_out,
	output logic [7:0] data_out,
	output logic last_out
);
	logic second;
	logic [7:0] held_type;
	wire take;
	assign take = valid_out && ready_in;
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			valid_out <= 1'b0;
			data_out <= 8'h00;
			last_out <= 1'b0;
			second <= 1'b0;
			held_type <= 8'h00;
		end
		else if (send_in && !valid_out)
		begin
			valid_out <= 1'b1;
			data_out <= {`TMCD_SKIP_OK, disc_in};
			last_out <= 1'b0;
			second <= 1'b0;
			held_type <= type_in;
		end
		else if (take && !second)
		begin
			data_out <= held_type;
			last_out <= 1'b1;
			second <= 1'b1;
		end
		else if (take)
		begin
			valid_out <= 1'b0;
			last_out <= 1'b0;
			second <= 1'b0;
		end
	end
endmodule

/* tb/test_mode_command_decoder_bench.sv */
`timescale 1ns/100ps
module test_mode_command_decoder_bench;
	logic clk_in = 0, nrst_in = 0, rx_valid_in = 0, rx_last_in = 0;
	logic mode_a_in = 0, stall = 0, ign = 0, ign_p, tx_ready_in;
	logic [2:0] aud_seq [5] = '{3'h1, 3'h2, 3'h4, 3'h0, 3'h2};
	logic [7:0] rx_data_in = 8'h00, tx_data_out;
	logic tx_valid_out, tx_last_out, link, mslot, pkt, unl, pay, loop;
	logic [2:0] aud, ts;
	logic [11:0] cnt;
	logic [10:0] len;
	logic [8:0] q[$];
	int error_cnt = 0, checked = 0, cyc = 0;
	tmcd_decoder tmcd_decoder_inst (.clk_in(clk_in), .nrst_in(nrst_in),
		.rx_valid_in(rx_valid_in), .rx_data_in(rx_data_in),
		.rx_last_in(rx_last_in), .tx_ready_in(tx_ready_in),
		.mode_a_in(mode_a_in), .tx_valid_out(tx_valid_out),
		.tx_data_out(tx_data_out), .tx_last_out(tx_last_out),
		.link_active_out(link), .mslot_open_out(mslot),
		.audio_route_out(aud), .pkt_test_out(pkt),
		.pdu_count_field_out(cnt), .pdu_unlimited_out(unl),
		.pdu_len_out(len), .pdu_payload_only_out(pay),
		.loopback_out(loop), .dl_ts_offset_out(ts), .ignored_out(ign_p));
	tmcd_sink tmcd_sink_inst (.clk_in(clk_in), .nrst_in(nrst_in),
		.stall_in(stall), .tx_ready_out(tx_ready_in));
	initial
	begin
		forever #10 clk_in = !clk_in;
	end
	always @(posedge clk_in)
	begin
		cyc++;
		if (tx_valid_out === 1'b1 && tx_ready_in === 1'b1)
			q.push_back({tx_last_out, tx_data_out});
		if (ign_p === 1'b1)
			ign <= 1'b1;
		if (cyc == 5000)
		begin
			error_cnt++;
			results();
		end
	end
	task results();
		if (error_cnt == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task chk(input string n, input logic [11:0] s, input logic [11:0] e);
		checked++;
		if (s !== e)
		begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	task send(input logic [39:0] m, input int n);
		for (int i = 0; i < n; i++)
		begin
			@(posedge clk_in);
			rx_valid_in <= 1'b1;
			rx_data_in <= m[39-8*i -: 8];
			rx_last_in <= (i == n - 1);
		end
		@(posedge clk_in);
		rx_valid_in <= 1'b0;
		rx_last_in <= 1'b0;
		repeat (14) @(posedge clk_in);
	endtask
	task reply(input int n, input logic [7:0] t);
		chk("reply_cnt", 12'(q.size()), 12'(n));
		if (n == 2 && q.size() == 2)
		begin
			chk("reply_hdr", 12'(q[0]), 12'h005);
			chk("reply_type", 12'(q[1]), {4'h1, t});
		end
		q.delete();
	endtask
	task pkt_chk(input logic [11:0] c, input logic u, l, input logic [2:0] o);
		chk("pdu_count", cnt, c);
		chk("unlimited", 12'(unl), 12'(u));
		chk("loopback", 12'(loop), 12'(l));
		chk("ts_offset", 12'(ts), 12'(o));
	endtask
	initial
	begin
		repeat (4) @(posedge clk_in);
		nrst_in <= 1'b1;
		chk("len_reset", 12'(len), 12'h08C);
		chk("link_reset", 12'(link), 12'h000);
		chk("mslot_reset", 12'(mslot), 12'h000);
		chk("pkt_reset", 12'(pkt), 12'h000);
		send({8'h05, 8'h0C, 24'h0}, 2);
		chk("link_on", 12'(link), 12'h001);
		reply(2, 8'h0D);
		stall <= 1'b1;
		send({8'h05, 8'h22, 24'h0}, 2);
		chk("mslot", 12'(mslot), 12'h001);
		reply(2, 8'h23);
		send({8'h05, 8'h10, 24'h0}, 2);
		chk("link_off", 12'(link), 12'h000);
		reply(0, 8'h00);
		chk("skip_none", 12'(ign), 12'h000);
		send({8'h15, 8'h0C, 24'h0}, 2);
		chk("skip_link", 12'(link), 12'h000);
		chk("skip_flag", 12'(ign), 12'h001);
		reply(0, 8'h00);
		for (int i = 0; i < 5; i++)
		begin
			send({8'h05, 8'h14, 5'h00, aud_seq[i], 16'h0}, 3);
			chk("audio", 12'(aud), 12'(aud_seq[i]));
		end
		send({8'h05, 8'h14, 8'hF9, 16'h0}, 3);
		chk("audio_spare", 12'(aud), 12'h001);
		send({8'h05, 8'h14, 8'h07, 16'h0}, 3);
		chk("audio_rsv", 12'(aud), 12'h001);
		mode_a_in <= 1'b1;
		send({8'h05, 8'h24, 8'h8A, 8'hBC, 8'h0B}, 5);
		pkt_chk(12'hABC, 1'b0, 1'b1, 3'h5);
		chk("pdu_len", 12'(len), 12'h618);
		chk("pkt_pay", 12'(pkt & pay), 12'h001);
		send({8'h05, 8'h24, 8'h00, 8'h10, 8'h0A}, 5);
		pkt_chk(12'hABC, 1'b0, 1'b1, 3'h5);
		mode_a_in <= 1'b0;
		send({8'h05, 8'h24, 8'h80, 8'h01, 8'h0E}, 5);
		pkt_chk(12'hABC, 1'b0, 1'b0, 3'h7);
		mode_a_in <= 1'b1;
		send({8'h05, 8'h24, 8'h80, 8'h00, 8'h01}, 5);
		pkt_chk(12'h000, 1'b1, 1'b1, 3'h0);
		send({8'h05, 8'h24, 8'h8F, 8'hFF, 8'h00}, 5);
		pkt_chk(12'hFFF, 1'b0, 1'b0, 3'h0);
		results();
	end
endmodule

/* tb/tmcd_asserts.sv */
`timescale 1ns/100ps
module tmcd_asserts (
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic tx_ready_in,
	input wire logic tx_valid_out,
	input wire logic [7:0] tx_data_out,
	input wire logic tx_last_out,
	input wire logic link_active_out,
	input wire logic [2:0] audio_route_out,
	input wire logic pkt_test_out,
	input wire logic [11:0] pdu_count_field_out,
	input wire logic pdu_unlimited_out,
	input wire logic [10:0] pdu_len_out,
	input wire logic pdu_payload_only_out,
	input wire logic ignored_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!nrst_in);
	a_reply_hold: assert property (tx_valid_out && !tx_ready_in |=>
		tx_valid_out && $stable(tx_data_out)) else $error("reply dropped");
	a_reply_pair: assert property (tx_valid_out && tx_ready_in &&
		!tx_last_out |=> tx_valid_out && tx_last_out) else $error("no type");
	a_reply_type: assert property (tx_valid_out && tx_last_out |->
		tx_data_out inside {8'h0D, 8'h23}) else $error("bad type");
	a_reply_hdr: assert property (tx_valid_out && !tx_last_out |->
		tx_data_out[7:4] == 4'h0) else $error("bad header");
	a_link_ack: assert property ($rose(link_active_out) |->
		tx_valid_out) else $error("no link reply");
	a_skip_quiet: assert property ($rose(ignored_out) |=>
		$stable(audio_route_out)[*3]) else $error("skip acted");
	a_audio_legal: assert property (audio_route_out inside
		{3'h0, 3'h1, 3'h2, 3'h4}) else $error("reserved route");
	a_len_range: assert property (pdu_len_out >= 11'h08C &&
		pdu_len_out <= 11'h618) else $error("length range");
	a_unl_zero: assert property (pdu_unlimited_out |->
		pdu_count_field_out == 12'h000) else $error("unlimited count");
	a_payload_only: assert property (pkt_test_out |->
		pdu_payload_only_out) else $error("payload flag");
	cover property (tx_valid_out && tx_last_out && tx_ready_in);
	cover property (ignored_out);
	cover property ($rose(pkt_test_out));
endmodule
bind tmcd_decoder tmcd_asserts tmcd_asserts_inst (.*);

/* tb/tmcd_sink.sv */
`timescale 1ns/100ps
module tmcd_sink (
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic stall_in,
	output logic tx_ready_out
);
	logic tgl;
	// Stalls every other cycle when asked
	always_ff @(posedge clk_in or negedge nrst_in)
		if (!nrst_in)
			tgl <= 1'b0;
		else
			tgl <= !tgl;
	assign tx_ready_out = !stall_in || tgl;
endmodule
